//--- inc/hcog_pkg.sv
package hcog_pkg;

  localparam int unsigned CLK_FREQ_HZ        = 250_000_000;
  // Carrier period in nanoseconds and the resulting count of clock cycles.
  localparam int unsigned CARRIER_PERIOD_NS  = 50_000;
  localparam int unsigned CARRIER_CYCLES     = CARRIER_PERIOD_NS / 4;
  localparam int unsigned HALF_CARRIER       = CARRIER_CYCLES / 2;
  // Dead time in nanoseconds; a least time, so the cycle count rounds up.
  localparam int unsigned DEAD_TIME_NS       = 2_000;
  localparam int unsigned DEAD_CYCLES        = (DEAD_TIME_NS + 3) / 4;
  // Raw speed-timer period constant, unused; the free-running timer is SPEED_W bits and wraps at 0x20000000.
  localparam logic [31:0] SPEED_PERIOD       = 32'h1000_0000;
  localparam int unsigned SPEED_W            = 29;
  localparam logic [2:0]  HALL_RESET         = 3'h0;
  localparam logic [2:0]  SECTOR_RESET       = 3'h0;
  localparam logic [5:0]  PATTERN_OFF        = 6'h00;

  typedef enum logic [1:0]
  {
    HCOG_RUN     = 2'b00,
    HCOG_TRIPPED = 2'b01,
    HCOG_IDLE    = 2'b10
  } hcog_guard_e;

  // Maps a hall code to a 60-degree sector; 7 marks an illegal code.
  function automatic logic [2:0] hcog_sector(input logic [2:0] hall);
    case (hall)
      3'h1:    hcog_sector = 3'h0;
      3'h3:    hcog_sector = 3'h1;
      3'h2:    hcog_sector = 3'h2;
      3'h6:    hcog_sector = 3'h3;
      3'h4:    hcog_sector = 3'h4;
      3'h5:    hcog_sector = 3'h5;
      default: hcog_sector = 3'h7;
    endcase
  endfunction

endpackage

//--- verilog/hcog_phase_pwm.sv
`timescale 1ns/100ps
`default_nettype none
// One complementary phase leg with dead time between its two switches.
module hcog_phase_pwm
  import hcog_pkg::*;
#(
  parameter int unsigned CNT_W = 14
)
(
  input  wire logic             clk,
  input  wire logic             resetn,
  input  wire logic             clk_en,
  input  wire logic [CNT_W-1:0] carrier,
  input  wire logic [CNT_W-1:0] duty,
  input  wire logic             hi_enable,
  input  wire logic             lo_enable,
  output logic                  hi_drive,
  output logic                  lo_drive
);

  logic             want_hi;
  logic             raw_hi_q;
  logic             raw_hi_d;
  logic [CNT_W-1:0] dead_q;
  logic [CNT_W-1:0] dead_d;
  logic             hi_d;
  logic             lo_d;

  always_comb
  begin
    want_hi  = (carrier < duty);
    raw_hi_d = raw_hi_q;
    dead_d   = dead_q;
    hi_d     = 1'b0;
    lo_d     = 1'b0;
    if (want_hi != raw_hi_q)
    begin
      raw_hi_d = want_hi;
      dead_d   = CNT_W'(DEAD_CYCLES);
    end
    else if (dead_q != '0)
    begin
      dead_d = dead_q - 1'b1;
    end
    else
    begin
      hi_d = raw_hi_q & hi_enable;
      lo_d = ~raw_hi_q & lo_enable;
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      raw_hi_q <= 1'b0;
      dead_q   <= '0;
      hi_drive <= 1'b0;
      lo_drive <= 1'b0;
    end
    else if (clk_en)
    begin
      raw_hi_q <= raw_hi_d;
      dead_q   <= dead_d;
      hi_drive <= hi_d;
      lo_drive <= lo_d;
    end
  end

endmodule // hcog_phase_pwm
`default_nettype wire

//--- verilog/hcog_guard.sv
`timescale 1ns/100ps
`default_nettype none
// Summary of operation
// - An overcurrent trip turns every PWM output pin to high impedance.
// - The trip is a low level on the overcurrent input, sampled on the clock.
// - Both rising and falling hall edges raise an event.
// - Each hall edge updates the position, captures a speed sample and changes the conduction pattern.
// - A free-running periodic speed timer with a raw period of 0x20000000 (2**SPEED_W) gives the speed time base.
// - Position resolves into six sectors of 60 electrical degrees.
// - Each phase is a complementary PWM pair with dead time between switch changes.
// - The PWM carrier period is 50 microseconds.
module hcog_guard
  import hcog_pkg::*;
#(
  parameter int unsigned CNT_W = 14
)
(
  input  wire logic               clk,
  input  wire logic               resetn,
  input  wire logic               clk_en,
  input  wire logic [2:0]         hall_edge_irq_input,
  input  wire logic               overcurrent_trip_input,
  input  wire logic               rearm,
  input  wire logic               run_enable,
  input  wire logic [CNT_W-1:0]   duty,
  output logic [2:0]              pwm_hi_out,
  output logic [2:0]              pwm_hi_oe,
  output logic [2:0]              pwm_lo_out,
  output logic [2:0]              pwm_lo_oe,
  output logic                    hall_event,
  output logic [2:0]              rotor_sector,
  output logic                    sector_valid,
  output logic [SPEED_W-1:0]      speed_sample,
  output logic                    speed_valid,
  output logic                    trip_event,
  output logic                    tripped
);

  initial
  begin
    if (CNT_W < 14 || CNT_W > 31)
      $error("hcog_guard: CNT_W must hold the carrier count.");
  end

  hcog_guard_e      state_q;
  hcog_guard_e      state_d;
  logic [2:0]       hall_q;
  logic [2:0]       sector_d;
  logic [5:0]       pattern_q;
  logic [5:0]       pattern_d;
  logic [CNT_W-1:0] carrier_q;
  logic [CNT_W-1:0] carrier_d;
  logic [SPEED_W-1:0] timer_q;
  logic [SPEED_W-1:0] timer_d;
  logic [SPEED_W-1:0] last_q;
  logic [SPEED_W-1:0] last_d;
  logic             edge_seen;
  logic             trip_now;
  logic [2:0]       leg_hi;
  logic [2:0]       leg_lo;
  logic [2:0]       hi_oe_d;
  logic [2:0]       lo_oe_d;
  logic [SPEED_W-1:0] sample_d;

  // Pattern bits: [5:3] high-side enables, [2:0] low-side enables, phase U at bit 0.
  function automatic logic [5:0] hcog_pattern(input logic [2:0] sector);
    case (sector)
      3'h0:    hcog_pattern = 6'h0A;
      3'h1:    hcog_pattern = 6'h0C;
      3'h2:    hcog_pattern = 6'h14;
      3'h3:    hcog_pattern = 6'h11;
      3'h4:    hcog_pattern = 6'h21;
      3'h5:    hcog_pattern = 6'h22;
      default: hcog_pattern = PATTERN_OFF;
    endcase
  endfunction

  always_comb
  begin
    edge_seen = (hall_edge_irq_input != hall_q);
    trip_now  = ~overcurrent_trip_input;
    sector_d  = hcog_sector(hall_edge_irq_input);
    // Carrier wraps every 50 us.
    carrier_d = (carrier_q == CNT_W'(CARRIER_CYCLES - 1)) ? '0 : carrier_q + 1'b1;
    // Timer wraps at 2**SPEED_W counts, free of any hall activity.
    timer_d   = timer_q + 1'b1;
    last_d    = last_q;
    sample_d  = speed_sample;
    pattern_d = pattern_q;
    state_d   = state_q;
    if (edge_seen)
    begin
      sample_d  = timer_q - last_q;
      last_d    = timer_q;
      pattern_d = hcog_pattern(sector_d);
    end
    unique case (state_q)
      HCOG_IDLE:
      begin
        if (trip_now)
          state_d = HCOG_TRIPPED;
        else if (run_enable)
          state_d = HCOG_RUN;
      end
      HCOG_RUN:
      begin
        if (trip_now)
          state_d = HCOG_TRIPPED;
        else if (!run_enable)
          state_d = HCOG_IDLE;
      end
      HCOG_TRIPPED:
      begin
        // Trip input high alone does not release; a re-arm is required.
        if (rearm && !trip_now)
          state_d = HCOG_IDLE;
      end
      default:
        state_d = HCOG_TRIPPED;
    endcase
    // Gate enables follow the next guard state (state_d), so they change in the same cycle as tripped.
    hi_oe_d = (state_d == HCOG_TRIPPED) ? 3'h0 : 3'h7;
    lo_oe_d = (state_d == HCOG_TRIPPED) ? 3'h0 : 3'h7;
  end

  genvar g;
  generate
    for (g = 0; g < 3; g++)
    begin : g_leg
      hcog_phase_pwm #(
        .CNT_W (CNT_W)
      ) u_leg (
        .clk       (clk),
        .resetn    (resetn),
        .clk_en    (clk_en),
        .carrier   (carrier_q),
        .duty      (duty),
        .hi_enable (pattern_q[g+3] && state_q == HCOG_RUN),
        .lo_enable (pattern_q[g] && state_q == HCOG_RUN),
        .hi_drive  (leg_hi[g]),
        .lo_drive  (leg_lo[g])
      );
    end
  endgenerate

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_q      <= HCOG_IDLE;
      hall_q       <= HALL_RESET;
      pattern_q    <= PATTERN_OFF;
      carrier_q    <= '0;
      timer_q      <= '0;
      last_q       <= '0;
      pwm_hi_out   <= 3'h0;
      pwm_lo_out   <= 3'h0;
      pwm_hi_oe    <= 3'h0;
      pwm_lo_oe    <= 3'h0;
      hall_event   <= 1'b0;
      rotor_sector <= SECTOR_RESET;
      sector_valid <= 1'b0;
      speed_sample <= '0;
      speed_valid  <= 1'b0;
      trip_event   <= 1'b0;
      tripped      <= 1'b0;
    end
    else if (clk_en)
    begin
      state_q      <= state_d;
      hall_q       <= hall_edge_irq_input;
      pattern_q    <= pattern_d;
      carrier_q    <= carrier_d;
      timer_q      <= timer_d;
      last_q       <= last_d;
      pwm_hi_out   <= leg_hi;
      pwm_lo_out   <= leg_lo;
      pwm_hi_oe    <= hi_oe_d;
      pwm_lo_oe    <= lo_oe_d;
      hall_event   <= edge_seen;
      if (edge_seen)
      begin
        rotor_sector <= sector_d;
        sector_valid <= (sector_d != 3'h7);
      end
      speed_sample <= sample_d;
      speed_valid  <= edge_seen;
      trip_event   <= (state_d == HCOG_TRIPPED) && (state_q != HCOG_TRIPPED);
      tripped      <= (state_d == HCOG_TRIPPED);
    end
  end

endmodule // hcog_guard
`default_nettype wire

//--- tb/hcog_guard_chk_properties.sv
`timescale 1ns/100ps
`default_nettype none
module hcog_guard_chk
(
  input wire logic       clk,
  input wire logic       resetn,
  input wire logic       clk_en,
  input wire logic [2:0] hall_edge_irq_input,
  input wire logic       overcurrent_trip_input,
  input wire logic       rearm,
  input wire logic [2:0] pwm_hi_out,
  input wire logic [2:0] pwm_hi_oe,
  input wire logic [2:0] pwm_lo_out,
  input wire logic [2:0] pwm_lo_oe,
  input wire logic       hall_event,
  input wire logic [2:0] rotor_sector,
  input wire logic       sector_valid,
  input wire logic       speed_valid,
  input wire logic       trip_event,
  input wire logic       tripped
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  a_trip_hiz: assert property (clk_en && !overcurrent_trip_input |=> tripped && (pwm_hi_oe | pwm_lo_oe) == 3'h0)
    else $error("trip did not float outputs");
  a_hiz_held: assert property (tripped |-> (pwm_hi_oe | pwm_lo_oe) == 3'h0)
    else $error("output enabled while tripped");
  a_trip_hold: assert property (tripped && !(clk_en && rearm && overcurrent_trip_input) |=> tripped)
    else $error("trip state left without rearm");
  a_rearm_exit: assert property (clk_en && tripped && rearm && overcurrent_trip_input |=> !tripped)
    else $error("rearm did not clear trip");
  a_trip_pulse: assert property ($rose(tripped) |-> trip_event ##1 !trip_event)
    else $error("trip event pulse wrong");
  a_hall_edge: assert property (hall_edge_irq_input != $past(hall_edge_irq_input) |=> hall_event)
    else $error("hall edge missed");
  a_hall_quiet: assert property ($stable(hall_edge_irq_input) |=> !hall_event)
    else $error("spurious hall event");
  a_speed_pair: assert property (hall_event |-> speed_valid)
    else $error("no speed sample with hall event");
  a_sector_range: assert property (sector_valid |-> rotor_sector <= 3'h5)
    else $error("sector out of range");
  a_legs_excl: assert property ((pwm_hi_out & pwm_lo_out) == 3'h0)
    else $error("both switches of a leg on");
endmodule // hcog_guard_chk
bind hcog_guard hcog_guard_chk u_chk (.*);
`default_nettype wire

//--- tb/hcog_plant.sv
`timescale 1ns/100ps
`default_nettype none
module hcog_plant
(
  input  wire logic clk,
  input  wire logic adv,
  input  wire logic bad,
  input  wire logic oc_req,
  output logic [2:0] hall_edge_irq_input,
  output logic       overcurrent_trip_input
);
  logic [2:0] idx_q = 3'h5;
  logic [2:0] nxt;
  logic [2:0] tab [6] = '{3'h1, 3'h3, 3'h2, 3'h6, 3'h4, 3'h5};
  initial hall_edge_irq_input = 3'h0;
  assign nxt = (idx_q == 3'h5) ? 3'h0 : idx_q + 3'h1;
  // The comparator pulls its output low only while an overcurrent is present.
  assign overcurrent_trip_input = !oc_req;
  always @(posedge clk)
    if (adv)
    begin
      if (!bad)
        idx_q <= nxt;
      hall_edge_irq_input <= bad ? 3'h7 : tab[nxt];
    end
endmodule // hcog_plant
`default_nettype wire

//--- tb/hall_commutation_overcurrent_guard_tb.sv
`timescale 1ns/100ps
`default_nettype none
module hall_commutation_overcurrent_guard_tb
  import hcog_pkg::*;
;
  typedef struct { logic [2:0] sec; int gap; } hcog_note_s;
  hcog_note_s notes [$];
  hcog_note_s nt;
  logic clk = 1'b0, resetn = 1'b0, clk_en = 1'b1, rearm = 1'b0, run_enable = 1'b0;
  logic adv = 1'b0, bad = 1'b0, oc_req = 1'b0;
  logic [13:0] duty = 14'h0000;
  logic [2:0] hall_edge_irq_input, pwm_hi_out, pwm_hi_oe, pwm_lo_out, pwm_lo_oe, rotor_sector;
  logic overcurrent_trip_input, hall_event, sector_valid, speed_valid, trip_event, tripped;
  logic [SPEED_W-1:0] speed_sample;
  int mismatches = 0, n_checks = 0, seed = 54, sec_i = 5, n_trips = 0;
  initial forever #2 clk = ~clk;
  hcog_guard #(.CNT_W(14)) uut (.*);
  hcog_plant u_plant (.*);
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string msg);
    n_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // The speed sample counts cycles back to the previous hall change, so g is the expected delta.
  task automatic step(input int g, input logic b, input logic k);
    if (!b)
      sec_i = (sec_i + 1) % 6;
    notes.push_back('{b ? 3'h7 : 3'(sec_i), k ? g : -1});
    repeat (g - 1) @(posedge clk);
    #1 adv = 1'b1;
    bad = b;
    tick(1);
    adv = 1'b0;
  endtask
  always @(posedge clk)
  begin
    #1;
    if (trip_event === 1'b1)
      n_trips++;
    if (hall_event === 1'b1)
    begin
      if (notes.size() == 0)
        cmp(1, 0, "unexpected hall event");
      else
      begin
        nt = notes.pop_front();
        cmp(rotor_sector, nt.sec, "sector");
        cmp(sector_valid, nt.sec != 3'h7, "sector valid");
        cmp(speed_valid, 1, "speed valid");
        if (nt.gap > 0) cmp(speed_sample, nt.gap, "speed sample");
      end
    end
  end
  initial
  begin
    #20000;
    mismatches++;
    close_out();
  end
  initial
  begin
    tick(20);
    resetn = 1'b1;
    run_enable = 1'b1;
    // Duty in the upper carrier half keeps the high side steady through the leg check below.
    duty = 14'(7000 + $unsigned($random(seed)) % 5000);
    tick(2);
    cmp(pwm_hi_oe & pwm_lo_oe, 3'h7, "outputs not enabled");
    step(5, 1'b0, 1'b0);
    for (int i = 0; i < 14; i++) step(2 + $unsigned($random(seed)) % 16, i == 7, 1'b1);
    tick(4);
    cmp(notes.size(), 0, "hall events missing");
    tick(520);
    cmp({|pwm_hi_out, pwm_lo_out}, 4'h8, "leg not driving");
    oc_req = 1'b1;
    tick(2);
    cmp({tripped, pwm_hi_oe, pwm_lo_oe}, 7'h40, "trip");
    rearm = 1'b1;
    tick(4);
    cmp(tripped, 1, "rearm during overcurrent");
    cmp(pwm_hi_out | pwm_lo_out, 3'h0, "legs still driving");
    rearm = 1'b0;
    oc_req = 1'b0;
    tick(6);
    cmp(tripped, 1, "trip released early");
    rearm = 1'b1;
    tick(3);
    rearm = 1'b0;
    cmp(tripped, 0, "rearm ignored");
    tick(2);
    cmp(pwm_hi_oe & pwm_lo_oe, 3'h7, "outputs not restored");
    cmp(n_trips, 1, "trip event count");
    close_out();
  end
endmodule // hall_commutation_overcurrent_guard_tb
`default_nettype wire
